/* hw/status_output_port.sv */
// Purpose: six programmable status outputs behind an apb slave
// Assumes: status words are synchronous to core_clk
// Notes: outputs are registered; one cycle after status changes
//
// Function
// - each output has its own function selector
// - conduct while selected function true
// - disabled selector holds output state
// - initialized, configured follow main bits 0,1
// - fault, alert follow main bits 2,3
// - four requirement flags follow main bits 4-7
// - seven ready flags follow main bits 8-14
// - op required, any busy: main 15,16
// - six busy flags follow main bits 17-22
// - autotrigger, parked, full follow bits 23-25
// - success pulse, last follow bits 26,27
// - seven phase busy follow ext bits 0-6
// - prime follows ext bit 8; bit 7 unselectable
// - crossover sync, waiting follow ext 16,17
// - invert reverses conduction sense
// - test mode drives outputs from value
// - one test switch forces all six outputs
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module status_output_port
(
  input wire logic core_clk, // 100 mhz system clock
  input wire logic reset, // sync, active high
  input wire logic clkEn, // freezes all state when low
  input wire logic [31:0] mainStatusIn, // main_status_word
  input wire logic [31:0] extStatusIn, // extended_status_word
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [3:0] logicOut, // logic outputs, high conducts
  output logic [1:0] auxOut // aux outputs, high conducts
);
  localparam int N = status_out_pkg::NUM_OUTPUTS;

  // ==========================================================
  // configuration storage
  status_out_pkg::out_cfg_type cfg_reg [N]; // one per output
  logic testMode_reg; // io_test_switch
  logic [N-1:0] outLevel; // driven levels
  status_out_pkg::status_words_type status; // bundled words

  assign status.main_status_word = mainStatusIn;
  assign status.extended_status_word = extStatusIn;

  // ==========================================================
  // address decode
  logic [N-1:0] hitSel; // selector register hit
  logic [N-1:0] hitInv; // invert register hit
  logic [N-1:0] hitVal; // value register hit
  logic hitTest; // test switch hit
  logic hitMainSt; // main word hit
  logic hitExtSt; // ext word hit
  logic anyHit; // mapped address
  logic wrStrobe; // write takes effect

  // per-output offsets: aux pair sits past the reserved logic slots
  function automatic logic [11:0] outOffs(input logic [11:0] base,
                                          input int idx);
    logic [11:0] o;
    o = base + 12'(idx * 4);
    if (idx >= status_out_pkg::LOGIC_COUNT)
      o = o + status_out_pkg::OFFS_AUX_STEP - 12'h010;
    return o;
  endfunction

  // compare address to every register
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      hitSel[i] = paddr == outOffs(status_out_pkg::OFFS_SEL_BASE, i);
      hitInv[i] = paddr == outOffs(status_out_pkg::OFFS_INV_BASE, i);
      hitVal[i] = paddr == outOffs(status_out_pkg::OFFS_VAL_BASE, i);
    end
    hitTest = paddr == status_out_pkg::OFFS_TEST_SWITCH;
    hitMainSt = paddr == status_out_pkg::OFFS_MAIN_STATUS;
    hitExtSt = paddr == status_out_pkg::OFFS_EXT_STATUS;
    anyHit = (|hitSel) | (|hitInv) | (|hitVal) | hitTest |
             hitMainSt | hitExtSt;
  end

  // zero wait states: access phase completes at once
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~anyHit;
  assign wrStrobe = psel & penable & pwrite & anyHit & clkEn;

  // ==========================================================
  // configuration writes, one set per output
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < N; i++)
      begin
        cfg_reg[i].select <= status_out_pkg::SEL_RESET;
        cfg_reg[i].invert <= 1'b0;
        cfg_reg[i].force_value <= 1'b0;
      end
    end
    else if (wrStrobe)
    begin
      for (int i = 0; i < N; i++)
      begin
        // independent selector per output
        if (hitSel[i])
          cfg_reg[i].select <=
            pwdata[status_out_pkg::SEL_WIDTH-1:0];
        if (hitInv[i])
          cfg_reg[i].invert <= pwdata[0];
        if (hitVal[i])
          cfg_reg[i].force_value <= pwdata[0];
      end
    end
  end

  // test switch register, common to all six outputs
  always_ff @(posedge core_clk)
  begin
    if (reset)
      testMode_reg <= 1'b0;
    else if (wrStrobe && hitTest)
      testMode_reg <= pwdata[0];
  end

  // ==========================================================
  // output channels
  generate
    for (genvar g = 0; g < N; g++)
    begin : gen_chan
      output_channel u_chan
      (
        .core_clk(core_clk),
        .reset(reset),
        .clkEn(clkEn),
        .status(status),
        .cfg(cfg_reg[g]),
        .testMode(testMode_reg),
        .outLevel(outLevel[g])
      );
    end
  endgenerate

  assign logicOut = outLevel[3:0];
  assign auxOut = outLevel[5:4];

  // ==========================================================
  // read data, registered at the edge that ends the setup phase
  logic [31:0] rdMux; // selected read word

  // unmapped and reserved bits read as zero
  always_comb
  begin
    rdMux = status_out_pkg::RDATA_RESET;
    for (int i = 0; i < N; i++)
    begin
      if (hitSel[i])
        rdMux = {26'h000_0000, cfg_reg[i].select};
      if (hitInv[i])
        rdMux = {31'h0000_0000, cfg_reg[i].invert};
      if (hitVal[i])
        // outside test, report the driven level
        rdMux = {31'h0000_0000,
                 testMode_reg ? cfg_reg[i].force_value : outLevel[i]};
    end
    if (hitTest)
      rdMux = {31'h0000_0000, testMode_reg};
    if (hitMainSt)
      rdMux = mainStatusIn;
    if (hitExtSt)
      rdMux = extStatusIn;
  end

  // prdata only moves on a read access
  always_ff @(posedge core_clk)
  begin
    if (reset)
      prdata <= status_out_pkg::RDATA_RESET;
    else if (psel && !penable && !pwrite && clkEn)
      prdata <= rdMux;
  end

endmodule // status_output_port

/* hw/status_out_pkg.sv */
// Purpose: shared constants and types for the status output port
// Assumes: 32-bit apb data, one aligned word per register
// Notes: selector codes are consecutive; unlisted codes act as disabled
package status_out_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_OUTPUTS = 6; // four logic then two aux
  localparam int SEL_WIDTH = 6; // selector code width
  localparam int NUM_CODES = 39; // disabled plus 38 choices

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFFS_MAIN_STATUS = 12'h030; // read only
  localparam logic [11:0] OFFS_EXT_STATUS = 12'h034; // read only
  localparam logic [11:0] OFFS_TEST_SWITCH = 12'h314; // io_test_switch
  localparam logic [11:0] OFFS_SEL_BASE = 12'h320; // output1 select
  localparam logic [11:0] OFFS_INV_BASE = 12'h350; // output1 invert
  localparam logic [11:0] OFFS_VAL_BASE = 12'h380; // output1 value
  localparam logic [11:0] OFFS_AUX_STEP = 12'h020; // aux1 sits 8 words on
  localparam int LOGIC_COUNT = 4; // outputs before the aux gap

  // ==========================================================
  // reset values
  localparam logic [SEL_WIDTH-1:0] SEL_RESET = 6'h00; // disabled
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ==========================================================
  // selector codes
  localparam logic [SEL_WIDTH-1:0] SEL_DISABLED = 6'h00;
  localparam logic [SEL_WIDTH-1:0] SEL_MAIN_FIRST = 6'h01; // main bit 0
  localparam logic [SEL_WIDTH-1:0] SEL_MAIN_LAST = 6'h1c; // main bit 27
  localparam logic [SEL_WIDTH-1:0] SEL_EXT_FIRST = 6'h1d; // ext bit 0
  localparam logic [SEL_WIDTH-1:0] SEL_EXT_LAST = 6'h23; // ext bit 6
  localparam logic [SEL_WIDTH-1:0] SEL_PRIME = 6'h24; // ext bit 8
  localparam logic [SEL_WIDTH-1:0] SEL_XOVER_SYNC = 6'h25; // ext bit 16
  localparam logic [SEL_WIDTH-1:0] SEL_XOVER_WAIT = 6'h26; // ext bit 17
  localparam int EXT_PRIME_BIT = 8;
  localparam int EXT_XSYNC_BIT = 16;
  localparam int EXT_XWAIT_BIT = 17;

  // ==========================================================
  // per-output configuration carrier
  typedef struct packed {
    logic [SEL_WIDTH-1:0] select; // function select
    logic invert; // polarity invert
    logic force_value; // forced level in test mode
  } out_cfg_type;

  typedef struct packed {
    logic [31:0] main_status_word;
    logic [31:0] extended_status_word;
  } status_words_type;

endpackage

/* hw/status_bit_mux.sv */
// Purpose: map one selector code to one status bit
// Assumes: status words come from logic on the same clock
// Notes: combinational; hold of disabled outputs is done by caller
`timescale 1ns/100ps
module status_bit_mux
(
  input wire status_out_pkg::status_words_type status, // both words
  input wire logic [status_out_pkg::SEL_WIDTH-1:0] select, // code
  output logic bitValue, // selected status bit
  output logic isActive // code names a real function
);
  // ==========================================================
  // decode
  logic [status_out_pkg::SEL_WIDTH-1:0] mainIdx; // main bit index
  logic [status_out_pkg::SEL_WIDTH-1:0] extIdx; // ext bit index

  // selector to bit, in listed order
  always_comb
  begin
    mainIdx = select - status_out_pkg::SEL_MAIN_FIRST;
    extIdx = select - status_out_pkg::SEL_EXT_FIRST;
    bitValue = 1'b0;
    isActive = 1'b1;
    if (select >= status_out_pkg::SEL_MAIN_FIRST &&
        select <= status_out_pkg::SEL_MAIN_LAST)
    begin
      // main word bits 0..27
      bitValue = status.main_status_word[mainIdx[4:0]];
      // busy, ready and success bits ride the same index
    end
    else if (select >= status_out_pkg::SEL_EXT_FIRST &&
             select <= status_out_pkg::SEL_EXT_LAST)
    begin
      bitValue = status.extended_status_word[extIdx[4:0]];
    end
    else if (select == status_out_pkg::SEL_PRIME)
    begin
      // ext bit 7 has no code at all
      bitValue =
        status.extended_status_word[status_out_pkg::EXT_PRIME_BIT];
    end
    else if (select == status_out_pkg::SEL_XOVER_SYNC)
    begin
      // synchronous crossover flag
      bitValue =
        status.extended_status_word[status_out_pkg::EXT_XSYNC_BIT];
    end
    else if (select == status_out_pkg::SEL_XOVER_WAIT)
    begin
      // crossover waiting flag
      bitValue =
        status.extended_status_word[status_out_pkg::EXT_XWAIT_BIT];
    end
    else
    begin
      // disabled and unlisted codes
      isActive = 1'b0;
    end
  end

endmodule // status_bit_mux

/* hw/output_channel.sv */
// Purpose: one switched output: select, invert, hold, force
// Assumes: clock enable freezes the held level
// Notes: outLevel high means the output conducts
`timescale 1ns/100ps
module output_channel
(
  input wire logic core_clk, // system clock
  input wire logic reset, // sync, active high
  input wire logic clkEn, // freezes state when low
  input wire status_out_pkg::status_words_type status, // status words
  input wire status_out_pkg::out_cfg_type cfg, // this output's setup
  input wire logic testMode, // io_test_switch
  output logic outLevel // conducting when high
);
  // ==========================================================
  // datapath
  logic selBit; // chosen status bit
  logic selActive; // selector not disabled
  logic level_reg; // driven level
  logic level_next; // next driven level

  status_bit_mux u_mux
  (
    .status(status),
    .select(cfg.select),
    .bitValue(selBit),
    .isActive(selActive)
  );

  // pick source: test force, hold, or status xor invert
  always_comb
  begin
    if (testMode)
      level_next = cfg.force_value;
    else if (!selActive)
      level_next = level_reg; // disabled holds last level
    else
      level_next = selBit ^ cfg.invert;
  end

  // registered so the pin never glitches on selector writes
  always_ff @(posedge core_clk)
  begin
    if (reset)
      level_reg <= 1'b0;
    else if (clkEn)
      level_reg <= level_next;
  end

  assign outLevel = level_reg;

endmodule // output_channel

/* dv/status_out_asserts.sv */
// Purpose: port-level checks for the status output port
// Assumes: one clock, sync active-high reset
// Notes: config is hidden, so outputs are tied to bus and status
`timescale 1ns/100ps
module status_out_asserts
(
  input wire logic core_clk, // clock
  input wire logic reset, // sync reset
  input wire logic clkEn, // clock enable
  input wire logic [31:0] mainStatusIn, // main word
  input wire logic [31:0] extStatusIn, // extended word
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [3:0] logicOut, // logic outputs
  input wire logic [1:0] auxOut // aux outputs
);
  // ==========================================================
  // clocking
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // no bus traffic and steady status words
  sequence quiet;
    clkEn && !psel && $stable(mainStatusIn) && $stable(extStatusIn);
  endsequence
  // ==========================================================
  // checks
  // two quiet cycles leave nothing that may move an output
  a_quiet_hold: assert property (quiet [*2] |=>
    $stable({logicOut, auxOut})) else $error("output moved unprompted");
  a_freeze_outs: assert property (!clkEn |=> $stable({logicOut, auxOut}))
    else $error("output moved while frozen");
  // reset checks must not be masked by the reset itself
  a_reset_outs: assert property (disable iff (1'b0)
    reset |=> logicOut == 4'h0 && auxOut == 2'h0)
    else $error("outputs not cleared by reset");
  a_reset_rdata: assert property (disable iff (1'b0)
    reset |=> prdata == 32'h0000_0000) else $error("prdata not cleared");
  a_ready_high: assert property (disable iff (1'b0) pready)
    else $error("pready dropped");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_err_unmapped: assert property (psel && penable && paddr == 12'h004
    |-> pslverr) else $error("unmapped access not refused");
  a_err_mapped: assert property (psel && penable &&
    paddr == status_out_pkg::OFFS_TEST_SWITCH |-> !pslverr)
    else $error("mapped access refused");
endmodule // status_out_asserts

bind status_output_port status_out_asserts u_chk (.core_clk, .reset,
  .clkEn, .mainStatusIn, .extStatusIn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .logicOut, .auxOut);

/* dv/field_loads.sv */
// Purpose: field loads wired to the six switched outputs
// Assumes: a conducting output energises its load at once
// Notes: loads hold no memory of their own
`timescale 1ns/100ps
module field_loads
(
  input wire logic [3:0] logicOut, // logic outputs
  input wire logic [1:0] auxOut, // aux outputs
  output logic [5:0] loadOn // energised loads, aux on top
);
  // ==========================================================
  // loads
  // current flows only through a conducting output
  assign loadOn = {auxOut, logicOut};
endmodule // field_loads

/* dv/programmable_status_output_port_test.sv */
// Purpose: self-checking bench for the status output port
// Assumes: zero-wait apb slave, outputs one edge behind inputs
// Notes: one table row per run of codes on consecutive bits of one word
`timescale 1ns/100ps
module programmable_status_output_port_test;
  // ==========================================================
  // signals
  logic core_clk, reset, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] mainStatusIn, extStatusIn, pwdata, prdata, rd;
  logic [11:0] paddr;
  logic [3:0] logicOut;
  logic [1:0] auxOut;
  logic [5:0] loadOn; // as the loads see it
  logic err; // pslverr taken at the access edge
  int n_fail, n_checks;
  // first code, last code, extended word, first bit
  typedef struct {int first, last, ext, bit0;} span_type;
  span_type rows[4] = '{'{1, 28, 0, 0}, '{29, 35, 1, 0},
    '{36, 36, 1, 8}, '{37, 38, 1, 16}};
  status_output_port uut (.core_clk, .reset, .clkEn, .mainStatusIn,
    .extStatusIn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .logicOut, .auxOut);
  field_loads loads (.logicOut, .auxOut, .loadOn);
  // ==========================================================
  // clock and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the whole run needs under a fifth of this
  initial
  begin
    #200_000;
    n_fail++;
    finish_test();
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] exp, act);
    n_checks++;
    if (act !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // pready high ends this wait; if it never comes, only the watchdog does
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // aux registers sit past a gap of four words
  function automatic logic [11:0] at(input logic [11:0] base, int i);
    return base + 12'(4 * i) + (i >= 4 ? 12'h010 : 12'h000);
  endfunction
  task automatic set_all(input int code, input logic inv);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, at(status_out_pkg::OFFS_SEL_BASE, i), 32'(code));
      xfer(1'b1, at(status_out_pkg::OFFS_INV_BASE, i), {31'h0, inv});
    end
  endtask
  task automatic settle(input logic [5:0] exp);
    repeat (2) @(posedge core_clk);
    check({26'h0, exp}, {26'h0, loadOn});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    int b;
    logic [31:0] word;
    n_fail = 0;
    n_checks = 0;
    reset = 1'b1;
    clkEn = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mainStatusIn, extStatusIn} = '0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // every code 1-38, plain and inverted, set bit alone then cleared alone
    foreach (rows[r])
      for (int c = rows[r].first; c <= rows[r].last; c++)
        for (int v = 0; v < 2; v++)
        begin
          b = rows[r].bit0 + c - rows[r].first;
          set_all(c, v[0]);
          word = 32'h0000_0001 << b;
          mainStatusIn <= rows[r].ext ? 32'h0000_0000 : word;
          extStatusIn <= rows[r].ext ? word : 32'h0000_0000;
          settle(v ? 6'h00 : 6'h3f);
          mainStatusIn <= rows[r].ext ? 32'hffff_ffff : ~word;
          extStatusIn <= rows[r].ext ? ~word : 32'hffff_ffff;
          settle(v ? 6'h3f : 6'h00);
        end
    // each output on its own main bit
    set_all(0, 1'b0);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, at(status_out_pkg::OFFS_SEL_BASE, i), 32'(i + 1));
    mainStatusIn <= 32'h0000_0029;
    settle(6'h29);
    // disabled and unlisted codes hold the conducting level
    set_all(1, 1'b0);
    mainStatusIn <= 32'h0000_0001;
    settle(6'h3f);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, at(status_out_pkg::OFFS_SEL_BASE, i),
        i < 2 ? 32'h0 : (i < 4 ? 32'h27 : 32'h3f));
    mainStatusIn <= 32'h0000_0000;
    settle(6'h3f);
    xfer(1'b0, at(status_out_pkg::OFFS_VAL_BASE, 5), 32'h0);
    check(32'h0000_0001, rd);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, at(status_out_pkg::OFFS_VAL_BASE, i), (32'h25 >> i) & 1);
    settle(6'h3f);
    // a write while frozen is lost
    clkEn <= 1'b0;
    xfer(1'b1, status_out_pkg::OFFS_TEST_SWITCH, 32'h1);
    clkEn <= 1'b1;
    settle(6'h3f);
    xfer(1'b1, status_out_pkg::OFFS_TEST_SWITCH, 32'h1);
    mainStatusIn <= 32'hffff_ffff;
    settle(6'h25);
    xfer(1'b0, at(status_out_pkg::OFFS_VAL_BASE, 0), 32'h0);
    check(32'h0000_0001, rd);
    xfer(1'b0, 12'h004, 32'h0);
    check(32'h0000_0001, {31'h0, err});
    check(32'h0000_0000, rd);
    // reset in mid-run clears outputs and selectors
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    check(32'h0000_0000, {26'h0, loadOn});
    xfer(1'b0, at(status_out_pkg::OFFS_SEL_BASE, 4), 32'h0);
    check(32'h0000_0000, rd);
    finish_test();
  end
endmodule // programmable_status_output_port_test
